// file: hdl/nmt_consts.svh
// Opcode patterns, instruction field positions and reset values for the move and table slice.
`ifndef NMT_CONSTS_SVH
`define NMT_CONSTS_SVH

`define NMT_OP9_WAKE_LOW    9'h092
`define NMT_OP9_PAGE_COPY   9'h0bf
`define NMT_OP9_PIN_COPY    9'h09e
`define NMT_OP5_WR_TO_RAM   5'h0f
`define NMT_OP5_RAM_TO_WR   5'h0d
`define NMT_OP9_PTR_LOW     9'h130
`define NMT_OP9_PTR_HIGH    9'h131
`define NMT_OP9_ROM_TO_RAM  9'h132
`define NMT_OP5_ROM_TO_WR   5'h15
`define NMT_OP9_OR_ACC      9'h074

`define NMT_OP9_MSB         15
`define NMT_OP9_LSB         7
`define NMT_OP5_MSB         15
`define NMT_OP5_LSB         11
`define NMT_WR_MSB          10
`define NMT_WR_LSB          7
`define NMT_ADDR_MSB        6
`define NMT_ADDR_LSB        0

`define NMT_WAKE_DIV0       0
`define NMT_WAKE_TMR0       1
`define NMT_WAKE_PIN        2
`define NMT_WAKE_DIV1       4
`define NMT_WAKE_TMR1       5

`define NMT_NIB_RESET       4'h0
`define NMT_WAKE_RESET      8'h00
`define NMT_WR_BASE         3'h0
`define NMT_PTR_PAD         3'h0

`endif

// file: hdl/nmt_lookup_if.sv
// Request and answer path between the decoder and the table reader.
interface nmt_lookup_if;
   logic                      req;
   nmt_pkg::nmt_rom_addr_type addr;
   nmt_pkg::nmt_nibble_type   data;

   modport requester (output req, output addr, input data);
   modport reader    (input req, input addr, output data);
endinterface

// file: hdl/nmt_move_table_core.sv
// Decode and execute logic for the move, table read and OR instructions of the nibble core.
`include "nmt_consts.svh"

// Behaviour
// - Prefix 010010010 copies wake flags 0..3 to RAM and accumulator, sets zero flag.
// - Wake flag bit 0 marks a hold exit by divider 0 overflow.
// - Wake flag bit 1 marks a hold exit by timer 0 underflow.
// - Wake flag bit 2 marks a pin-change hold exit; bit 3 reads zero.
// - Page copy opcode copies page select into RAM and accumulator, sets zero flag.
// - Prefix 010011110 copies pin change flags to RAM and accumulator, sets zero flag.
// - Each pin change flag goes to one when its pin changes level and holds until a pin copy clears it.
// - Prefix 01111 copies a working register to accumulator and RAM in one cycle.
// - Prefix 01101 copies a RAM nibble to working register and accumulator.
// - Prefix 100110000 loads a RAM nibble into the low table pointer.
// - Prefix 100110001 loads a RAM nibble into the high table pointer.
// - Prefix 100110010 reads table ROM at high*10H+low in two cycles.
// - Prefix 10101 reads table ROM at immediate*10H+accumulator into a working register.
// - Prefix 001110100 ORs RAM with accumulator into accumulator only, sets zero flag.
// - Upper wake flag bit 0 marks divider 1 overflow, bit 1 timer 1 underflow.
module nmt_move_table_core
   import nmt_pkg::*;
#(
   parameter int RAM_WORDS = 128
)
(
   // Clock and reset.
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Instruction stream.
   input  wire logic                    instrValid,
   input  wire logic [15:0]             instrWord,
   output logic                         instrReady,
   output logic                         instrDone,
   // Hold exit causes and hold entry.
   input  wire logic                    holdEnter,
   input  wire logic                    wakeDiv0,
   input  wire logic                    wakeTimer0,
   input  wire logic                    wakePinChange,
   input  wire logic                    wakeDiv1,
   input  wire logic                    wakeTimer1,
   // Change-sensing port and page select.
   input  wire nmt_pkg::nmt_nibble_type changeSensePort,
   input  wire nmt_pkg::nmt_nibble_type ramPageSelect,
   // Table ROM pins.
   output nmt_pkg::nmt_rom_addr_type    romAddr,
   input  wire nmt_pkg::nmt_nibble_type romData,
   // Visible core state.
   output nmt_pkg::nmt_nibble_type      accumulator,
   output logic                         zeroResultFlag,
   output nmt_pkg::nmt_nibble_type      lookupPointerLow,
   output nmt_pkg::nmt_nibble_type      lookupPointerHigh,
   output nmt_pkg::nmt_nibble_type      pinChangeFlags,
   output logic [7:0]                   holdWakeCauseFlags,
   // RAM observation port.
   input  wire nmt_pkg::nmt_ram_addr_type ramProbeAddr,
   output nmt_pkg::nmt_nibble_type      ramProbeData
);
   import nmt_pkg::*;

   nmt_nibble_type   ram [RAM_WORDS];
   nmt_state_type    state;
   nmt_ram_addr_type tableDest;
   nmt_nibble_type   pinPrev;
   logic             pinPrimed;

   nmt_kind_type     kind;
   nmt_ram_addr_type opAddr;
   nmt_ram_addr_type wrAddr;
   nmt_nibble_type   ramRd;
   nmt_nibble_type   wrVal;
   nmt_nibble_type   wakeCauseLowNibble;
   logic             fire;
   logic             ramWe;
   nmt_ram_addr_type ramWAddr;
   nmt_nibble_type   ramWData;
   logic             accWe;
   nmt_nibble_type   accVal;
   logic             pinRead;
   nmt_nibble_type   pinChanged;

   nmt_lookup_if lkp ();

   function automatic nmt_kind_type decodeOp(input logic [15:0] w);
      logic [8:0] op9;
      logic [4:0] op5;
      op9 = w[`NMT_OP9_MSB:`NMT_OP9_LSB];
      op5 = w[`NMT_OP5_MSB:`NMT_OP5_LSB];
      if (op9 == `NMT_OP9_WAKE_LOW)        decodeOp = NMT_K_WAKE_LOW;
      else if (op9 == `NMT_OP9_PAGE_COPY)  decodeOp = NMT_K_PAGE;
      else if (op9 == `NMT_OP9_PIN_COPY)   decodeOp = NMT_K_PIN;
      else if (op5 == `NMT_OP5_WR_TO_RAM)  decodeOp = NMT_K_WR_TO_RAM;
      else if (op5 == `NMT_OP5_RAM_TO_WR)  decodeOp = NMT_K_RAM_TO_WR;
      else if (op9 == `NMT_OP9_PTR_LOW)    decodeOp = NMT_K_PTR_LOW;
      else if (op9 == `NMT_OP9_PTR_HIGH)   decodeOp = NMT_K_PTR_HIGH;
      else if (op9 == `NMT_OP9_ROM_TO_RAM) decodeOp = NMT_K_ROM_TO_RAM;
      else if (op5 == `NMT_OP5_ROM_TO_WR)  decodeOp = NMT_K_ROM_TO_WR;
      else if (op9 == `NMT_OP9_OR_ACC)     decodeOp = NMT_K_OR_ACC;
      else                                 decodeOp = NMT_K_IDLE;
   endfunction

   // Working registers are the bottom sixteen RAM nibbles.
   function automatic nmt_ram_addr_type wrToRam(input logic [3:0] idx);
      wrToRam = {`NMT_WR_BASE, idx};
   endfunction

   nmt_table_reader u_reader (
      .clk     (clk),
      .rst     (rst),
      .lkp     (lkp.reader),
      .romAddr (romAddr),
      .romData (romData)
   );

   assign kind   = decodeOp(instrWord);
   assign opAddr = instrWord[`NMT_ADDR_MSB:`NMT_ADDR_LSB];
   assign wrAddr = wrToRam(instrWord[`NMT_WR_MSB:`NMT_WR_LSB]);
   assign ramRd  = ram[opAddr];
   assign wrVal  = ram[wrAddr];
   assign wakeCauseLowNibble = holdWakeCauseFlags[3:0];
   assign instrReady = (state == NMT_RUN);
   assign fire       = instrValid && instrReady;

   // Table reads stall the stream for one extra cycle while the ROM answers.
   always_comb begin
      lkp.req   = 1'b0;
      lkp.addr  = '0;
      ramWe     = 1'b0;
      ramWAddr  = opAddr;
      ramWData  = `NMT_NIB_RESET;
      accWe     = 1'b0;
      accVal    = `NMT_NIB_RESET;
      pinRead   = 1'b0;
      if (state == NMT_TABLE) begin
         ramWe    = 1'b1;
         ramWAddr = tableDest;
         ramWData = lkp.data;
      end else if (fire) begin
         unique case (kind)
            NMT_K_WAKE_LOW: begin
               accVal = wakeCauseLowNibble;
               accWe  = 1'b1;
               ramWe  = 1'b1;
            end
            NMT_K_PAGE: begin
               accVal = ramPageSelect;
               accWe  = 1'b1;
               ramWe  = 1'b1;
            end
            NMT_K_PIN: begin
               accVal  = pinChangeFlags;
               accWe   = 1'b1;
               ramWe   = 1'b1;
               pinRead = 1'b1;
            end
            NMT_K_WR_TO_RAM: begin
               accVal = wrVal;
               accWe  = 1'b1;
               ramWe  = 1'b1;
            end
            NMT_K_RAM_TO_WR: begin
               accVal   = ramRd;
               accWe    = 1'b1;
               ramWe    = 1'b1;
               ramWAddr = wrAddr;
            end
            NMT_K_ROM_TO_RAM: begin
               lkp.req  = 1'b1;
               lkp.addr = {`NMT_PTR_PAD, lookupPointerHigh, lookupPointerLow};
            end
            NMT_K_ROM_TO_WR: begin
               lkp.req  = 1'b1;
               lkp.addr = {opAddr, accumulator};
            end
            NMT_K_OR_ACC: begin
               accVal = ramRd | accumulator;
               accWe  = 1'b1;
            end
            NMT_K_PTR_LOW, NMT_K_PTR_HIGH, NMT_K_IDLE: begin
               accWe = 1'b0;
            end
         endcase
         ramWData = accVal;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state     <= NMT_RUN;
         tableDest <= '0;
      end else begin
         unique case (state)
            NMT_RUN: begin
               if (fire && kind == NMT_K_ROM_TO_RAM) begin
                  state     <= NMT_TABLE;
                  tableDest <= opAddr;
               end else if (fire && kind == NMT_K_ROM_TO_WR) begin
                  state     <= NMT_TABLE;
                  tableDest <= wrAddr;
               end
            end
            NMT_TABLE: begin
               state <= NMT_RUN;
            end
            default: begin
               state <= NMT_RUN;
            end
         endcase
      end
   end

   // RAM has no reset; software initialises it as on the real part.
   always_ff @(posedge clk) begin
      if (ramWe) begin
         ram[ramWAddr] <= ramWData;
      end
      ramProbeData <= ram[ramProbeAddr];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         accumulator    <= `NMT_NIB_RESET;
         zeroResultFlag <= 1'b0;
      end else if (accWe) begin
         accumulator    <= accVal;
         zeroResultFlag <= (accVal == `NMT_NIB_RESET);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lookupPointerLow  <= `NMT_NIB_RESET;
         lookupPointerHigh <= `NMT_NIB_RESET;
      end else if (fire && kind == NMT_K_PTR_LOW) begin
         lookupPointerLow  <= ramRd;
      end else if (fire && kind == NMT_K_PTR_HIGH) begin
         lookupPointerHigh <= ramRd;
      end
   end

   // A cause that lands in the hold entry cycle survives: set wins over clear.
   always_ff @(posedge clk) begin
      if (rst) begin
         holdWakeCauseFlags <= `NMT_WAKE_RESET;
      end else begin
         holdWakeCauseFlags <= holdEnter ? `NMT_WAKE_RESET : holdWakeCauseFlags;
         if (wakeDiv0)      holdWakeCauseFlags[`NMT_WAKE_DIV0] <= 1'b1;
         if (wakeTimer0)    holdWakeCauseFlags[`NMT_WAKE_TMR0] <= 1'b1;
         if (wakePinChange) holdWakeCauseFlags[`NMT_WAKE_PIN]  <= 1'b1;
         if (wakeDiv1)      holdWakeCauseFlags[`NMT_WAKE_DIV1] <= 1'b1;
         if (wakeTimer1)    holdWakeCauseFlags[`NMT_WAKE_TMR1] <= 1'b1;
      end
   end

   // The first sample after reset only primes the history, so reset causes no false change.
   assign pinChanged = pinPrimed ? (changeSensePort ^ pinPrev) : `NMT_NIB_RESET;

   always_ff @(posedge clk) begin
      if (rst) begin
         pinPrev        <= `NMT_NIB_RESET;
         pinPrimed      <= 1'b0;
         pinChangeFlags <= `NMT_NIB_RESET;
      end else begin
         pinPrev        <= changeSensePort;
         pinPrimed      <= 1'b1;
         pinChangeFlags <= (pinRead ? `NMT_NIB_RESET : pinChangeFlags) | pinChanged;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         instrDone <= 1'b0;
      end else begin
         instrDone <= (state == NMT_TABLE) ||
                      (fire && kind != NMT_K_ROM_TO_RAM && kind != NMT_K_ROM_TO_WR);
      end
   end
endmodule // nmt_move_table_core

// file: hdl/nmt_pkg.sv
// Types shared by the move and table slice of the nibble core.
package nmt_pkg;
   typedef logic [3:0] nmt_nibble_type;
   typedef logic [6:0] nmt_ram_addr_type;
   typedef logic [10:0] nmt_rom_addr_type;

   typedef enum logic [1:0] {
      NMT_RUN   = 2'b01,
      NMT_TABLE = 2'b10
   } nmt_state_type;

   typedef enum logic [3:0] {
      NMT_K_IDLE, NMT_K_WAKE_LOW, NMT_K_PAGE, NMT_K_PIN, NMT_K_WR_TO_RAM,
      NMT_K_RAM_TO_WR, NMT_K_PTR_LOW, NMT_K_PTR_HIGH, NMT_K_ROM_TO_RAM,
      NMT_K_ROM_TO_WR, NMT_K_OR_ACC
   } nmt_kind_type;
endpackage

// file: hdl/nmt_table_reader.sv
// Look-up table ROM access: registers the address, returns the word one cycle later.
module nmt_table_reader
   import nmt_pkg::*;
(
   // Clock and reset.
   input  wire logic            clk,
   input  wire logic            rst,
   // Decoder side.
   nmt_lookup_if.reader         lkp,
   // ROM pins.
   output nmt_pkg::nmt_rom_addr_type romAddr,
   input  wire nmt_pkg::nmt_nibble_type romData
);
   // The address only moves on a request, so the ROM output stays stable between reads.
   always_ff @(posedge clk) begin
      if (rst) begin
         romAddr <= '0;
      end else if (lkp.req) begin
         romAddr <= lkp.addr;
      end
   end

   assign lkp.data = romData;
endmodule // nmt_table_reader

// file: tb/nmt_move_table_checker.sv
// Port assertions for the move and table slice of the nibble core.
module nmt_move_table_checker
   import nmt_pkg::*;
(
   // Clock and reset.
   input wire logic           clk,
   input wire logic           rst,
   // Instruction stream.
   input wire logic           instrValid,
   input wire logic [15:0]    instrWord,
   input wire logic           instrReady,
   input wire logic           instrDone,
   // Sources and state.
   input wire logic           wakeDiv0,
   input wire nmt_nibble_type ramPageSelect,
   input wire nmt_rom_addr_type romAddr,
   input wire nmt_nibble_type accumulator,
   input wire logic           zeroResultFlag,
   input wire nmt_nibble_type lookupPointerLow,
   input wire nmt_nibble_type lookupPointerHigh,
   input wire nmt_nibble_type pinChangeFlags,
   input wire logic [7:0]     holdWakeCauseFlags
);
   logic       take;
   logic       tbl;
   logic [8:0] op9;
   assign take = instrValid && instrReady;
   assign op9 = instrWord[15:7];
   assign tbl = take && (op9 == 9'h132 || instrWord[15:11] == 5'h15);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_wake_copy_acc: assert property (take && op9 == 9'h092 |=>
      accumulator == $past(holdWakeCauseFlags[3:0])) else $error("wake copy value");
   a_page_copy_acc: assert property (take && op9 == 9'h0bf |=>
      accumulator == $past(ramPageSelect)) else $error("page copy value");
   a_pin_copy_acc: assert property (take && op9 == 9'h09e |=>
      accumulator == $past(pinChangeFlags)) else $error("pin copy value");
   a_zero_flag_track: assert property (take && (op9 inside {9'h092, 9'h0bf, 9'h09e,
      9'h074} || instrWord[15:11] inside {5'h0f, 5'h0d}) |=>
      zeroResultFlag == (accumulator == 4'h0)) else $error("zero flag");
   a_or_keeps_bits: assert property (take && op9 == 9'h074 |=>
      (accumulator & $past(accumulator)) == $past(accumulator)) else $error("or lost bits");
   a_table_two_cycles: assert property (tbl |=> !instrReady && !instrDone
      ##1 instrReady && instrDone) else $error("table timing");
   a_table_ptr_addr: assert property (take && op9 == 9'h132 |=>
      romAddr == {3'h0, lookupPointerHigh, lookupPointerLow}) else $error("pointer address");
   a_table_imm_addr: assert property (take && instrWord[15:11] == 5'h15 |=>
      romAddr == {$past(instrWord[6:0]), $past(accumulator)}) else $error("immediate address");
   a_table_acc_kept: assert property (tbl |=> $stable(accumulator)[*2])
      else $error("table read moved accumulator");
   a_wake_div_set: assert property (wakeDiv0 |=> holdWakeCauseFlags[0])
      else $error("divider wake flag");
   a_reserved_zero: assert property (!holdWakeCauseFlags[3] &&
      holdWakeCauseFlags[7:6] == 2'b00) else $error("reserved wake bits");
   c_ptr_table: cover property (take && op9 == 9'h132);
   c_imm_table: cover property (take && instrWord[15:11] == 5'h15);
   c_or_acc: cover property (take && op9 == 9'h074);
endmodule // nmt_move_table_checker

bind nmt_move_table_core nmt_move_table_checker chk_u (.clk(clk), .rst(rst),
   .instrValid(instrValid), .instrWord(instrWord), .instrReady(instrReady),
   .instrDone(instrDone), .wakeDiv0(wakeDiv0), .ramPageSelect(ramPageSelect),
   .romAddr(romAddr), .accumulator(accumulator), .zeroResultFlag(zeroResultFlag),
   .lookupPointerLow(lookupPointerLow), .lookupPointerHigh(lookupPointerHigh),
   .pinChangeFlags(pinChangeFlags), .holdWakeCauseFlags(holdWakeCauseFlags));

// file: tb/testbench.sv
// Self-checking bench for the move and table slice of the nibble core.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        instrValid = 1'b0;
   logic        holdEnter = 1'b0;
   logic [15:0] instrWord = 16'h0000;
   logic [4:0]  wake = 5'h00;
   logic [3:0]  sense = 4'h0;
   logic [3:0]  page = 4'h0;
   logic [6:0]  probe = 7'h00;
   logic        instrReady, instrDone, zf;
   logic [10:0] romAddr;
   logic [3:0]  romData, acc, lpl, lph, pcf, probeData;
   logic [7:0]  hwf;
   int          fail_count = 0;
   int          check_count = 0;
   // The ROM stand-in answers at once; its content is a cheap function of the address.
   assign romData = romAddr[3:0] ^ romAddr[7:4];
   always #5 clk = ~clk;
   nmt_move_table_core dut_u (.clk(clk), .rst(rst), .instrValid(instrValid),
      .instrWord(instrWord), .instrReady(instrReady), .instrDone(instrDone),
      .holdEnter(holdEnter), .wakeDiv0(wake[0]), .wakeTimer0(wake[1]),
      .wakePinChange(wake[2]), .wakeDiv1(wake[3]), .wakeTimer1(wake[4]),
      .changeSensePort(sense), .ramPageSelect(page), .romAddr(romAddr),
      .romData(romData), .accumulator(acc), .zeroResultFlag(zf),
      .lookupPointerLow(lpl), .lookupPointerHigh(lph), .pinChangeFlags(pcf),
      .holdWakeCauseFlags(hwf), .ramProbeAddr(probe), .ramProbeData(probeData));
   task test_done();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task chk(input logic [10:0] got, input logic [10:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task exec(input logic [15:0] w);
      int n;
      @(negedge clk);
      instrValid = 1'b1;
      instrWord = w;
      @(negedge clk);
      instrValid = 1'b0;
      n = 0;
      while (instrDone !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      if (instrDone !== 1'b1) begin
         fail_count++;
         $display("wrong value at %0t: no completion", $time);
         test_done();
      end
   endtask
   task rd(input logic [6:0] a, input logic [3:0] e);
      probe = a;
      @(negedge clk);
      chk(probeData, e);
   endtask
   task poke(input logic [6:0] a, input logic [3:0] v);
      page = v;
      exec({9'h0bf, a});
   endtask
   task sc_page();
      logic [3:0] v;
      for (int i = 0; i < 3; i++) begin
         v = 4'h7 * i[3:0];
         poke(7'h40 + i[6:0], v);
         chk(acc, v);
         chk(zf, v == 4'h0);
         rd(7'h40 + i[6:0], v);
      end
   endtask
   task sc_wake();
      for (int i = 0; i < 5; i++) begin
         @(negedge clk);
         wake = 5'h01 << i;
         @(negedge clk);
         wake = 5'h00;
         @(negedge clk);
         chk(hwf, i < 3 ? 8'h01 << i : 8'h02 << i);
         holdEnter = 1'b1;
         @(negedge clk);
         holdEnter = 1'b0;
      end
      wake = 5'h1f;
      @(negedge clk);
      wake = 5'h00;
      exec({9'h092, 7'h21});
      chk(acc, 4'h7);
      rd(7'h21, 4'h7);
      holdEnter = 1'b1;
      @(negedge clk);
      holdEnter = 1'b0;
      exec({9'h092, 7'h21});
      chk(zf, 1'b1);
   endtask
   task sc_pin();
      sense = 4'ha;
      repeat (3) @(negedge clk);
      chk(pcf, 4'ha);
      exec({9'h09e, 7'h22});
      chk(acc, 4'ha);
      rd(7'h22, 4'ha);
      chk(pcf, 4'h0);
   endtask
   task sc_moves();
      poke(7'h03, 4'h9);
      // Move the accumulator away first, so the copy has something to change.
      poke(7'h57, 4'h2);
      exec({5'h0f, 4'h3, 7'h55});
      chk(acc, 4'h9);
      rd(7'h55, 4'h9);
      poke(7'h56, 4'h0);
      poke(7'h05, 4'h6);
      exec({5'h0d, 4'h5, 7'h56});
      chk({acc, zf}, 5'h01);
      rd(7'h05, 4'h0);
   endtask
   task sc_table();
      poke(7'h10, 4'h3);
      poke(7'h11, 4'hc);
      exec({9'h130, 7'h10});
      chk(lpl, 4'h3);
      exec({9'h131, 7'h11});
      chk(lph, 4'hc);
      exec({9'h132, 7'h20});
      chk(romAddr, 11'h0c3);
      chk(acc, 4'hc);
      rd(7'h20, 4'hf);
      exec({5'h15, 4'h2, 7'h15});
      chk(romAddr, {7'h15, 4'hc});
      rd(7'h02, 4'h9);
   endtask
   task sc_or_idle();
      poke(7'h30, 4'h1);
      poke(7'h31, 4'h8);
      exec({9'h074, 7'h30});
      chk({acc, zf}, 5'h12);
      rd(7'h30, 4'h1);
      exec(16'hffff);
      chk({acc, zf}, 5'h12);
      chk({lpl, lph}, 8'h3c);
   endtask
   // A mid-run reset with the change port away from zero must not leave a false change.
   task sc_reset();
      wake = 5'h1f;
      sense = 4'h5;
      @(negedge clk);
      chk(hwf, 8'h37);
      chk(pcf, 4'hf);
      wake = 5'h00;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      chk({acc, zf}, 5'h00);
      chk({lpl, lph}, 8'h00);
      chk(hwf, 8'h00);
      chk(pcf, 4'h0);
      chk({instrReady, instrDone}, 2'b10);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      sc_page();
      sc_wake();
      sc_pin();
      sc_moves();
      sc_table();
      sc_or_idle();
      sc_reset();
      test_done();
   end
endmodule // testbench
